// [hdl/scdr_cfg.svh]
`ifndef SCDR_CFG_SVH
`define SCDR_CFG_SVH
`define SCDR_FRAME_BITS 32
`define SCDR_CMD_MSB 31
`define SCDR_CMD_LSB 28
`define SCDR_CRC_INIT 8'hFF
`define SCDR_CRC_POLY 8'h2F
`define SCDR_ST_ERROR 2'h3
`define SCDR_ST_OK 2'h0
`define SCDR_ECHO_READ 4'h6
`define SCDR_ECHO_WRITE 4'h4
`endif

// [hdl/scdr_pkg.sv]
package scdr_pkg;
   typedef enum logic [4:0] {
      SCDR_CMD_NONE = 5'h01,
      SCDR_CMD_SENSOR = 5'h02,
      SCDR_CMD_WRITE = 5'h04,
      SCDR_CMD_READ = 5'h08,
      SCDR_CMD_RSVD = 5'h10
   } scdr_cmd_t;
endpackage : scdr_pkg

// [hdl/scdr_sync.sv]
`timescale 1ns/100ps
module scdr_sync (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic d,
   output logic q
);
   logic s1_reg;
   logic s2_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end
   assign q = s2_reg;
endmodule : scdr_sync

// [hdl/scdr_crc8.sv]
`timescale 1ns/100ps
`include "scdr_cfg.svh"
// Replaceable CRC: swap polynomial/seed via the SCDR_CRC_POLY and SCDR_CRC_INIT macros only
module scdr_crc8 (
   input wire logic [23:0] data,
   output logic [7:0] crc
);
   always_comb begin
      logic [7:0] c;
      c = `SCDR_CRC_INIT;
      for (int i = 23; i >= 0; i--) begin
         if (c[7] ^ data[i]) begin
            c = {c[6:0], 1'b0} ^ `SCDR_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc = c;
   end
endmodule : scdr_crc8

// [hdl/scdr_top.sv]
`timescale 1ns/100ps
`include "scdr_cfg.svh"
module scdr_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ss_n,
   output logic miso,
   output logic miso_oe,
   input wire logic miso_err,
   input wire logic [1:0] basic_status,
   input wire logic [1:0] detail_status,
   input wire logic sensor_valid,
   input wire logic [11:0] sensor_sample,
   output logic [6:0] reg_word_addr,
   input wire logic [7:0] reg_even_data,
   input wire logic [7:0] reg_odd_data,
   output logic sensor_req,
   output logic [2:0] data_source_id,
   output logic spi_err
);
   logic sclk_s;
   logic mosi_s;
   logic ss_n_s;
   logic sclk_d_reg;
   logic ss_d_reg;
   logic [31:0] rx_reg, rx_next;
   logic [31:0] tx_reg, tx_next;
   logic [5:0] cnt_reg, cnt_next;
   logic miso_reg, miso_next;
   logic oe_reg, oe_next;
   logic [6:0] addr_reg, addr_next;
   logic sreq_reg, sreq_next;
   logic [2:0] src_reg, src_next;
   logic err_reg, err_next;
   logic [7:0] crc_rx;
   logic [7:0] crc_tx;
   logic [23:0] tx_body;
   logic rise;
   logic fall;
   logic ss_fall;
   logic ss_rise;
   scdr_pkg::scdr_cmd_t kind;

   // Pins come from another domain; 320 ns link clock vs 40 ns gives margin
   scdr_sync u_sync_sclk (.clk(clk), .arst_n(arst_n), .d(sclk), .q(sclk_s));
   scdr_sync u_sync_mosi (.clk(clk), .arst_n(arst_n), .d(mosi), .q(mosi_s));
   scdr_sync u_sync_ss (.clk(clk), .arst_n(arst_n), .d(ss_n), .q(ss_n_s));

   scdr_crc8 u_crc_rx (.data(rx_reg[31:8]), .crc(crc_rx));
   scdr_crc8 u_crc_tx (.data(tx_body), .crc(crc_tx));

   assign rise = sclk_s & ~sclk_d_reg & ~ss_n_s;
   assign fall = ~sclk_s & sclk_d_reg & ~ss_n_s;
   assign ss_fall = ~ss_n_s & ss_d_reg;
   assign ss_rise = ss_n_s & ~ss_d_reg;

   // Decode of the completed frame's command nibble
   always_comb begin
      kind = scdr_pkg::SCDR_CMD_RSVD;
      if (rx_reg[28]) begin
         kind = scdr_pkg::SCDR_CMD_SENSOR;
      end else begin
         unique case (rx_reg[31:28])
            4'h0: kind = scdr_pkg::SCDR_CMD_NONE;
            4'h8: kind = scdr_pkg::SCDR_CMD_WRITE;
            4'hC: kind = scdr_pkg::SCDR_CMD_READ;
            default: kind = scdr_pkg::SCDR_CMD_RSVD;
         endcase
      end
   end

   // Response body built at select rise, sent in the next frame
   always_comb begin
      logic bad;
      logic [1:0] st;
      bad = (crc_rx != rx_reg[7:0]) | (cnt_reg != 6'h20);
      st = basic_status;
      tx_body = 24'h000000;
      unique case (kind)
         scdr_pkg::SCDR_CMD_READ: begin
            // Reserved bits or data byte nonzero give the error status reply, without setting spi_err
            if (bad | miso_err | (rx_reg[27:24] != 4'h0) |
                (rx_reg[15:8] != 8'h00)) begin
               tx_body = {4'h0, `SCDR_ST_ERROR, 2'h0,
                          reg_odd_data, reg_even_data};
            end else begin
               tx_body = {`SCDR_ECHO_READ, st, 2'h0,
                          reg_odd_data, reg_even_data};
            end
         end
         scdr_pkg::SCDR_CMD_SENSOR: begin
            if (bad | ~sensor_valid) begin
               tx_body = {4'h0, `SCDR_ST_ERROR, 16'h0000,
                          detail_status};
            end else begin
               tx_body = {rx_reg[28], rx_reg[31:29], st,
                          sensor_sample, 4'h0, detail_status};
            end
         end
         scdr_pkg::SCDR_CMD_WRITE: begin
            tx_body = {4'h0, `SCDR_ST_ERROR, 2'h0,
                       reg_odd_data, reg_even_data};
         end
         default: begin
            tx_body = {4'h0, `SCDR_ST_ERROR, 16'h0000, detail_status};
         end
      endcase
   end

   always_comb begin
      rx_next = rx_reg;
      tx_next = tx_reg;
      cnt_next = cnt_reg;
      miso_next = miso_reg;
      oe_next = oe_reg;
      addr_next = addr_reg;
      sreq_next = 1'b0;
      src_next = src_reg;
      err_next = err_reg;
      if (ss_fall) begin
         cnt_next = 6'h00;
         oe_next = 1'b1;
         miso_next = tx_reg[31];
      end else if (rise && cnt_reg != 6'h20) begin
         rx_next = {rx_reg[30:0], mosi_s};
         cnt_next = cnt_reg + 6'h01;
      end else if (fall) begin
         tx_next = {tx_reg[30:0], 1'b0};
         miso_next = tx_reg[30];
      end
      // Address settles once all 32 bits are in, well before select rises
      if (cnt_reg == 6'h20 && kind == scdr_pkg::SCDR_CMD_READ) begin
         addr_next = rx_reg[23:17];
      end
      if (ss_rise) begin
         oe_next = 1'b0;
         miso_next = 1'b0;
         tx_next = {tx_body, crc_tx};
         err_next = (crc_rx != rx_reg[7:0]) | (cnt_reg != 6'h20);
         if (kind == scdr_pkg::SCDR_CMD_READ) begin
            addr_next = rx_reg[23:17];
         end
         if (kind == scdr_pkg::SCDR_CMD_SENSOR) begin
            sreq_next = 1'b1;
            src_next = rx_reg[31:29];
         end
      end
   end

   // Word address comes from a flop so the map sees a clean value
   assign reg_word_addr = addr_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_d_reg <= 1'b0;
         ss_d_reg <= 1'b1;
         rx_reg <= 32'h00000000;
         tx_reg <= {4'h0, `SCDR_ST_ERROR, 26'h0000000};
         cnt_reg <= 6'h00;
         miso_reg <= 1'b0;
         oe_reg <= 1'b0;
         addr_reg <= 7'h00;
         sreq_reg <= 1'b0;
         src_reg <= 3'h0;
         err_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         ss_d_reg <= ss_n_s;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         cnt_reg <= cnt_next;
         miso_reg <= miso_next;
         oe_reg <= oe_next;
         addr_reg <= addr_next;
         sreq_reg <= sreq_next;
         src_reg <= src_next;
         err_reg <= err_next;
      end
   end

   assign miso = miso_reg;
   assign miso_oe = oe_reg;
   assign sensor_req = sreq_reg;
   assign data_source_id = src_reg;
   assign spi_err = err_reg;

   a_read_echo: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_READ && !err_next && !miso_err
      && rx_reg[27:24] == 4'h0 && rx_reg[15:8] == 8'h00
      |=> tx_reg[31:28] == `SCDR_ECHO_READ)
      else $error("read echo wrong");
   a_read_bytes: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_READ
      |=> tx_reg[23:8] == {$past(reg_odd_data), $past(reg_even_data)})
      else $error("read data order wrong");
   a_read_error: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_READ && miso_err
      |=> tx_reg[31:26] == 6'h03)
      else $error("read error frame missing");
   a_sensor_err: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_SENSOR && !sensor_valid
      |=> tx_reg[31:10] == 22'h030000)
      else $error("sensor error frame wrong");
   a_sensor_echo: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_SENSOR && sensor_valid
      && !err_next |=> tx_reg[31:28] == {$past(rx_reg[28]),
      $past(rx_reg[31:29])})
      else $error("sensor echo wrong");
   a_source_id: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && rx_reg[28] |=> sensor_req && data_source_id ==
      $past(rx_reg[31:29]))
      else $error("source id wrong");
   a_zero_ignored: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && rx_reg[31:28] == 4'h0 |=> !sensor_req)
      else $error("code zero acted on");
   a_word_addr: assert property (@(posedge clk) disable iff (!arst_n)
      ss_rise && kind == scdr_pkg::SCDR_CMD_READ
      |=> reg_word_addr == $past(rx_reg[23:17]))
      else $error("word address wrong");
   a_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      ss_n_s && ss_d_reg |=> !miso_oe && $stable(rx_reg))
      else $error("active while deselected");
endmodule : scdr_top

// [dv/scdr_master.sv]
`timescale 1ns/100ps
module scdr_master (
   output logic sclk,
   output logic mosi,
   output logic ss_n,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      mosi = 1'b0;
      ss_n = 1'b1;
   end
   // Clock idles low and stands still between frames; MSB first
   task automatic xfer(input logic [31:0] tx, input int n,
         output logic [31:0] rx);
      rx = 32'h0;
      ss_n = 1'b0;
      #40;
      for (int i = 31; i > 31 - n; i--) begin
         mosi = tx[i];
         #160;
         sclk = 1'b1;
         rx = {rx[30:0], miso};
         #160;
         sclk = 1'b0;
      end
      #160;
      ss_n = 1'b1;
      // Deselected line flips so a stale bit cannot pass for data
      mosi = ~mosi;
   endtask : xfer
endmodule : scdr_master

// [dv/tb_top.sv]
`timescale 1ns/100ps
`include "scdr_cfg.svh"
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic sclk, mosi, ss_n, miso, miso_oe, sensor_req, spi_err;
   logic miso_err = 1'b0;
   logic [1:0] basic_status = 2'h0;
   logic [1:0] detail_status = 2'h0;
   logic sensor_valid = 1'b0;
   logic [11:0] sensor_sample = 12'h000;
   logic [6:0] reg_word_addr, a;
   logic [7:0] reg_even_data = 8'h00;
   logic [7:0] reg_odd_data = 8'h00;
   logic [2:0] data_source_id;
   logic [31:0] rx, exp_w, seed_v;
   logic [5:0] prev_top;
   logic [3:0] cd;
   logic bad;
   int n_errors = 0;
   int comparisons = 0;
   int n_pulse = 0;
   always #20 clk = ~clk;
   scdr_master m (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso(miso));
   scdr_top dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .mosi(mosi),
      .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe), .miso_err(miso_err),
      .basic_status(basic_status), .detail_status(detail_status),
      .sensor_valid(sensor_valid), .sensor_sample(sensor_sample),
      .reg_word_addr(reg_word_addr), .reg_even_data(reg_even_data),
      .reg_odd_data(reg_odd_data), .sensor_req(sensor_req),
      .data_source_id(data_source_id), .spi_err(spi_err));
   function automatic logic [7:0] ev(input logic [6:0] x);
      return {x, 1'b0} ^ 8'hA5;
   endfunction : ev
   function automatic logic [7:0] od(input logic [6:0] x);
      return {x, 1'b1} ^ 8'h3C;
   endfunction : od
   always @(posedge clk) begin
      reg_even_data <= ev(reg_word_addr);
      reg_odd_data <= od(reg_word_addr);
      if (sensor_req === 1'b1) n_pulse++;
   end
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = `SCDR_CRC_INIT;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SCDR_CRC_POLY : 8'h00);
      return c;
   endfunction : crc8
   function automatic logic [5:0] top(input logic [3:0] c);
      if (c == 4'hC) return {`SCDR_ECHO_READ, basic_status};
      if (c[0] && sensor_valid) return {c[0], c[3:1], basic_status};
      return {4'h0, `SCDR_ST_ERROR};
   endfunction : top
   function automatic logic [31:0] resp(input logic [6:0] x, input logic e);
      logic [23:0] b;
      b = {e ? 4'h0 : `SCDR_ECHO_READ, e ? `SCDR_ST_ERROR : basic_status,
         2'b00, od(x), ev(x)};
      return {b, crc8(b)};
   endfunction : resp
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic run(input logic [23:0] b, input logic [7:0] flip,
         input int n);
      n_pulse = 0;
      m.xfer({b, crc8(b) ^ flip}, n, rx);
      repeat (8) @(posedge clk);
   endtask : run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      #2000000;
      n_errors++;
      end_of_test();
   end
   initial begin
      seed_v = $urandom(58);
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge clk);
      prev_top = {4'h0, `SCDR_ST_ERROR};
      for (int c = 0; c < 16; c++) begin
         cd = c[3:0];
         @(posedge clk);
         sensor_valid <= 1'($urandom);
         basic_status <= 2'($urandom);
         detail_status <= 2'($urandom);
         sensor_sample <= 12'($urandom);
         @(posedge clk);
         run({cd, 20'h00000}, 8'h00, 32);
         check("echo", rx[31:26], prev_top);
         check("pulse", n_pulse, cd[0]);
         if (cd[0]) check("source", data_source_id, cd[3:1]);
         prev_top = top(cd);
      end
      $display("test command codes done");
      for (int k = 0; k < 8; k++) begin
         a = 7'($urandom);
         bad = (k == 5);
         @(posedge clk);
         miso_err <= (k == 3);
         basic_status <= 2'($urandom);
         @(posedge clk);
         // Fixed zeros and word address as the master must send
         run({4'hC, 4'h0, a, k[0], 8'h00}, {7'h0, bad}, 32);
         if (k == 0) check("echo", rx[31:26], prev_top);
         else check("read", rx, exp_w);
         check("word_addr", reg_word_addr, a);
         check("spi_err", spi_err, bad);
         exp_w = resp(a, (k == 3) || bad);
      end
      run({4'h1, 20'h00000}, 8'h00, 32);
      check("read", rx, exp_w);
      $display("test register reads done");
      run({4'h1, 20'h00000}, 8'h00, 31);
      check("spi_err", spi_err, 1'b1);
      check("miso_oe", miso_oe, 1'b0);
      $display("test short frame done");
      end_of_test();
   end
endmodule : tb_top
